// ==== tlvic_cfg.svh ====
// register offsets, field positions and reset values of the irq controller
`ifndef TLVIC_CFG_SVH
`define TLVIC_CFG_SVH
`define TLVIC_TMRCTL_ADDR 8'h88
`define TLVIC_ENA_ADDR 8'ha8
`define TLVIC_PRIO_ADDR 8'hb8
`define TLVIC_EVSTAT_ADDR 8'he8
`define TLVIC_EVMASK_ADDR 8'he9
`define TLVIC_GLOBAL_BIT 7
`define TLVIC_ENA_WMASK 8'hbf
`define TLVIC_TMR1_FLAG_BIT 7
`define TLVIC_TMR1_RUN_BIT 6
`define TLVIC_TMR0_FLAG_BIT 5
`define TLVIC_TMR0_RUN_BIT 4
`define TLVIC_EXT1_FLAG_BIT 3
`define TLVIC_EXT1_TRIG_BIT 2
`define TLVIC_EXT0_FLAG_BIT 1
`define TLVIC_EXT0_TRIG_BIT 0
`define TLVIC_EV_TAKEN_BIT 0
`define TLVIC_EV_NESTED_BIT 1
`define TLVIC_EV_EXT0_BIT 2
`define TLVIC_EV_EXT1_BIT 3
`define TLVIC_ENA_RESET 8'h00
`define TLVIC_PRIO_RESET 6'h00
`define TLVIC_TMRCTL_RESET 8'h00
`define TLVIC_EVMASK_RESET 4'h0
`define TLVIC_PIN_IDLE 1'b1
`define TLVIC_VEC_LOW 3'h3
`endif

// ==== tlvic_pkg.sv ====
// types shared by the irq controller modules
`include "tlvic_cfg.svh"
package tlvic_pkg;
   // register port from software
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tlvic_bus_type;
   // handshake from the processor core
   typedef struct packed {
      logic ack;
      logic reti;
   } tlvic_core_type;
   // source index, which is also the polling order
   typedef enum logic [2:0] {
      SRC_EXT0 = 3'h0,
      SRC_TMR0 = 3'h1,
      SRC_EXT1 = 3'h2,
      SRC_TMR1 = 3'h3,
      SRC_UART = 3'h4,
      SRC_TMR2 = 3'h5
   } tlvic_src_type;
   // whole state of the controller
   typedef struct packed {
      logic [7:0] irqEnable;
      logic [5:0] irqPriority;
      logic [7:0] timerCtrl;
      logic [1:0] inService;
      logic reqValid;
      logic reqHigh;
      logic [2:0] reqSrc;
      logic [15:0] reqVector;
      logic [1:0] pinPrev;
      logic [3:0] evStatus;
      logic [3:0] evMask;
      logic [7:0] rdData;
   } tlvic_state_type;
   // vectors sit eight bytes apart from the first one
   function automatic logic [15:0] tlvicVector(input logic [2:0] idx);
      return {10'h000, idx, `TLVIC_VEC_LOW};
   endfunction
endpackage

// ==== tlvic_pin_sync.sv ====
// three-stage synchroniser for the external request pins
`timescale 1ns/1ps
`include "tlvic_cfg.svh"
module tlvic_pin_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // pins and settled levels
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] level
);
   import tlvic_pkg::*;
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } tlvic_sync_type;
   tlvic_sync_type st_q;
   tlvic_sync_type st_d;
   initial begin
      if (WIDTH < 1) $error("width must be at least one");
   end
   // a change counts only once stages two and three agree
   always_comb begin
      st_d = st_q;
      st_d.s1 = pinIn;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.lvl[i] = st_q.s3[i];
         end
      end
   end
   // pins idle high, so the chain starts high
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q <= {(4 * WIDTH){`TLVIC_PIN_IDLE}};
      end else begin
         st_q <= st_d;
      end
   end
   assign level = st_q.lvl;
endmodule

// ==== tlvic_prio_pick.sv ====
// fixed-order picker: lowest set bit wins
`timescale 1ns/1ps
module tlvic_prio_pick #(
   parameter int N = 6
) (
   // candidate requests
   input wire logic [N-1:0] req,
   // winner
   output logic valid,
   output logic [2:0] idx
);
   import tlvic_pkg::*;
   initial begin
      if (N < 1 || N > 8) $error("picker serves one to eight sources");
   end
   // scan downward so the lowest index is left standing
   always_comb begin
      valid = |req;
      idx = 3'h0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = 3'(i);
         end
      end
   end
endmodule

// ==== tlvic_top.sv ====
// two-level vectored interrupt controller with timer control bits
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "tlvic_cfg.svh"
module tlvic_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // register port
   input wire tlvic_pkg::tlvic_bus_type regBus,
   output logic [7:0] rdData,
   // external request pins, asynchronous
   input wire logic extRequest0Pin,
   input wire logic extRequest1Pin,
   // peripheral events on this clock
   input wire logic timer0Overflow,
   input wire logic timer1Overflow,
   input wire logic uartRxDone,
   input wire logic uartTxDone,
   input wire logic timer2OverflowFlag,
   input wire logic timer2ExternalFlag,
   // timer run controls
   output logic timer0Run,
   output logic timer1Run,
   // processor core handshake
   input wire tlvic_pkg::tlvic_core_type coreIn,
   output logic irqReq,
   output logic irqHigh,
   output logic [15:0] irqVector,
   // software interrupt line
   output logic intOut
);
   import tlvic_pkg::*;

   localparam tlvic_state_type ST_RESET = '{
      irqEnable: `TLVIC_ENA_RESET,
      irqPriority: `TLVIC_PRIO_RESET,
      timerCtrl: `TLVIC_TMRCTL_RESET,
      pinPrev: {2{`TLVIC_PIN_IDLE}},
      evMask: `TLVIC_EVMASK_RESET,
      default: '0
   };

   tlvic_state_type st_q;
   tlvic_state_type st_d;
   logic [1:0] extLevel;
   logic [1:0] extFall;
   logic [5:0] srcFlags;
   logic [5:0] gated;
   logic [5:0] hiCand;
   logic [5:0] loCand;
   logic hiValid;
   logic loValid;
   logic [2:0] hiIdx;
   logic [2:0] loIdx;
   logic takeAck;
   logic globalOn;
   logic offerLive;

   // pins cross into the system clock here
   tlvic_pin_sync #(
      .WIDTH(2)
   ) pinSync (
      .clk_sys(clk_sys),
      .reset(reset),
      .pinIn({extRequest1Pin, extRequest0Pin}),
      .level(extLevel)
   );

   // falling edges of the settled pin levels
   assign extFall = st_q.pinPrev & ~extLevel;

   // pending flags in polling order
   // source bit order
   assign srcFlags = {
      timer2OverflowFlag | timer2ExternalFlag,
      uartRxDone | uartTxDone,
      st_q.timerCtrl[`TLVIC_TMR1_FLAG_BIT],
      st_q.timerCtrl[`TLVIC_EXT1_FLAG_BIT],
      st_q.timerCtrl[`TLVIC_TMR0_FLAG_BIT],
      st_q.timerCtrl[`TLVIC_EXT0_FLAG_BIT]
   };

   assign globalOn = st_q.irqEnable[`TLVIC_GLOBAL_BIT];
   assign gated = srcFlags & st_q.irqEnable[5:0] & {6{globalOn}};
   assign hiCand = gated & st_q.irqPriority;
   assign loCand = gated & ~st_q.irqPriority;

   tlvic_prio_pick #(
      .N(6)
   ) hiPick (
      .req(hiCand),
      .valid(hiValid),
      .idx(hiIdx)
   );

   tlvic_prio_pick #(
      .N(6)
   ) loPick (
      .req(loCand),
      .valid(loValid),
      .idx(loIdx)
   );

   // gate the standing offer too
   // an offer judged before software dropped an enable must not be taken after
   assign offerLive = st_q.reqValid && globalOn && st_q.irqEnable[st_q.reqSrc];
   // the core only takes what is offered
   assign takeAck = coreIn.ack && offerLive;

   // next state
   always_comb begin
      st_d = st_q;
      st_d.pinPrev = extLevel;
      st_d.rdData = 8'h00;
      // software writes come first so hardware sets win below
      if (regBus.wr) begin
         case (regBus.addr)
            `TLVIC_ENA_ADDR: begin
               st_d.irqEnable = regBus.wdata & `TLVIC_ENA_WMASK;
            end
            `TLVIC_PRIO_ADDR: begin
               st_d.irqPriority = regBus.wdata[5:0];
            end
            `TLVIC_TMRCTL_ADDR: begin
               st_d.timerCtrl = regBus.wdata;
            end
            `TLVIC_EVSTAT_ADDR: begin
               st_d.evStatus = st_q.evStatus & ~regBus.wdata[3:0];
            end
            `TLVIC_EVMASK_ADDR: begin
               st_d.evMask = regBus.wdata[3:0];
            end
            default: begin
            end
         endcase
      end
      // return from a handler retires the innermost level
      if (coreIn.reti) begin
         if (st_q.inService[1]) begin
            st_d.inService[1] = 1'b0;
         end else begin
            st_d.inService[0] = 1'b0;
         end
      end
      // vector taken: mark level busy and clear the flag of an edge-mode ext0 or ext1, timer 0 or timer 1 source
      if (takeAck) begin
         st_d.inService[st_q.reqHigh] = 1'b1;
         st_d.evStatus[`TLVIC_EV_TAKEN_BIT] = 1'b1;
         if (st_q.reqHigh && st_q.inService[0]) begin
            st_d.evStatus[`TLVIC_EV_NESTED_BIT] = 1'b1;
         end
         case (st_q.reqSrc)
            SRC_EXT0: begin
               st_d.timerCtrl[`TLVIC_EXT0_FLAG_BIT] = 1'b0;
            end
            SRC_TMR0: begin
               st_d.timerCtrl[`TLVIC_TMR0_FLAG_BIT] = 1'b0;
            end
            SRC_EXT1: begin
               st_d.timerCtrl[`TLVIC_EXT1_FLAG_BIT] = 1'b0;
            end
            SRC_TMR1: begin
               st_d.timerCtrl[`TLVIC_TMR1_FLAG_BIT] = 1'b0;
            end
            default: begin
               // uart and timer2 flags belong to their owners
            end
         endcase
      end
      if (timer0Overflow) begin
         st_d.timerCtrl[`TLVIC_TMR0_FLAG_BIT] = 1'b1;
      end
      if (timer1Overflow) begin
         st_d.timerCtrl[`TLVIC_TMR1_FLAG_BIT] = 1'b1;
      end
      if (st_q.timerCtrl[`TLVIC_EXT0_TRIG_BIT]) begin
         if (extFall[0]) begin
            st_d.timerCtrl[`TLVIC_EXT0_FLAG_BIT] = 1'b1;
         end
      end else begin
         // level mode tracks the pin, no latch
         st_d.timerCtrl[`TLVIC_EXT0_FLAG_BIT] = ~extLevel[0];
      end
      if (st_q.timerCtrl[`TLVIC_EXT1_TRIG_BIT]) begin
         if (extFall[1]) begin
            st_d.timerCtrl[`TLVIC_EXT1_FLAG_BIT] = 1'b1;
         end
      end else begin
         st_d.timerCtrl[`TLVIC_EXT1_FLAG_BIT] = ~extLevel[1];
      end
      // edge events for the software line
      if (extFall[0]) begin
         st_d.evStatus[`TLVIC_EV_EXT0_BIT] = 1'b1;
      end
      if (extFall[1]) begin
         st_d.evStatus[`TLVIC_EV_EXT1_BIT] = 1'b1;
      end
      // no same-level preemption
      // offer drops for a cycle after ack or return, since the
      // in-service bits it was judged on are about to change
      st_d.reqValid = 1'b0;
      st_d.reqHigh = 1'b0;
      st_d.reqSrc = 3'h0;
      st_d.reqVector = 16'h0000;
      if (!takeAck && !coreIn.reti) begin
         if (hiValid && !st_q.inService[1]) begin
            st_d.reqValid = 1'b1;
            st_d.reqHigh = 1'b1;
            st_d.reqSrc = hiIdx;
            st_d.reqVector = tlvicVector(hiIdx);
         end else if (loValid && st_q.inService == 2'h0) begin
            st_d.reqValid = 1'b1;
            st_d.reqSrc = loIdx;
            st_d.reqVector = tlvicVector(loIdx);
         end
      end
      // read data stand for one cycle only
      if (regBus.rd) begin
         case (regBus.addr)
            `TLVIC_ENA_ADDR: begin
               st_d.rdData = st_q.irqEnable;
            end
            `TLVIC_PRIO_ADDR: begin
               st_d.rdData = {2'h0, st_q.irqPriority};
            end
            `TLVIC_TMRCTL_ADDR: begin
               st_d.rdData = st_q.timerCtrl;
            end
            `TLVIC_EVSTAT_ADDR: begin
               st_d.rdData = {4'h0, st_q.evStatus};
            end
            `TLVIC_EVMASK_ADDR: begin
               st_d.rdData = {4'h0, st_q.evMask};
            end
            default: begin
               st_d.rdData = 8'h00;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q <= ST_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from state
   assign rdData = st_q.rdData;
   assign timer0Run = st_q.timerCtrl[`TLVIC_TMR0_RUN_BIT];
   assign timer1Run = st_q.timerCtrl[`TLVIC_TMR1_RUN_BIT];
   assign irqReq = offerLive;
   assign irqHigh = st_q.reqHigh;
   assign irqVector = st_q.reqVector;
   // level line, high while an unmasked event bit stands
   assign intOut = |(st_q.evStatus & st_q.evMask);

   // checks on the controller's own behaviour
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   sequence s_ack;
      coreIn.ack && irqReq;
   endsequence

   sequence s_ext0Fall;
      st_q.timerCtrl[`TLVIC_EXT0_TRIG_BIT] && extFall[0];
   endsequence

   property p_globalOff;
      !globalOn |-> !irqReq;
   endproperty
   a_globalOff: assert property (p_globalOff)
      else $error("request offered with global enable off");

   property p_srcOff;
      !st_q.irqEnable[0] |-> !(irqReq && irqVector == 16'h0003);
   endproperty
   a_srcOff: assert property (p_srcOff)
      else $error("disabled source offered");

   property p_vector;
      irqReq |-> irqVector[2:0] == 3'h3 && irqVector[15:6] == 10'h000
         && irqVector[5:3] == st_q.reqSrc;
   endproperty
   a_vector: assert property (p_vector)
      else $error("vector does not match source");

   property p_highLevel;
      (hiValid && st_q.inService == 2'h0 && !coreIn.ack && !coreIn.reti && !regBus.wr)
         |=> irqReq && irqHigh;
   endproperty
   a_highLevel: assert property (p_highLevel)
      else $error("high level request not offered as high");

   property p_noPreemptHigh;
      st_q.inService[1] |-> !irqReq;
   endproperty
   a_noPreemptHigh: assert property (p_noPreemptHigh)
      else $error("request offered over high handler");

   property p_nestOnlyHigh;
      st_q.inService[0] && irqReq |-> irqHigh;
   endproperty
   a_nestOnlyHigh: assert property (p_nestOnlyHigh)
      else $error("low request offered over low handler");

   property p_order;
      (loCand[0] && loCand[1] && !hiValid && st_q.inService == 2'h0
         && !coreIn.ack && !coreIn.reti && !regBus.wr) |=> irqReq && st_q.reqSrc == 3'h0;
   endproperty
   a_order: assert property (p_order)
      else $error("polling order broken");

   property p_tmr0Clear;
      (s_ack and (st_q.reqSrc == 3'h1 && !timer0Overflow && !regBus.wr))
         |=> !st_q.timerCtrl[`TLVIC_TMR0_FLAG_BIT];
   endproperty
   a_tmr0Clear: assert property (p_tmr0Clear)
      else $error("timer flag not cleared on vector");

   property p_tmr0Set;
      timer0Overflow |=> st_q.timerCtrl[`TLVIC_TMR0_FLAG_BIT];
   endproperty
   a_tmr0Set: assert property (p_tmr0Set)
      else $error("overflow did not set flag");

   property p_runWrite;
      regBus.wr && regBus.addr == `TLVIC_TMRCTL_ADDR
         |=> timer0Run == $past(regBus.wdata[4]) && timer1Run == $past(regBus.wdata[6]);
   endproperty
   a_runWrite: assert property (p_runWrite)
      else $error("run bits not taken from write");

   property p_edgeSet;
      s_ext0Fall |=> st_q.timerCtrl[`TLVIC_EXT0_FLAG_BIT] ##1 (!irqReq || $past(globalOn));
   endproperty
   a_edgeSet: assert property (p_edgeSet)
      else $error("falling edge did not set flag");

   property p_levelMode;
      !st_q.timerCtrl[`TLVIC_EXT0_TRIG_BIT]
         |=> st_q.timerCtrl[`TLVIC_EXT0_FLAG_BIT] == !$past(extLevel[0]);
   endproperty
   a_levelMode: assert property (p_levelMode)
      else $error("level mode flag does not track pin");
endmodule

// ==== tlvic_core_model.sv ====
// behavioural processor core that takes vectors and runs handlers
`timescale 1ns/1ps
module tlvic_core_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // offer from the controller
   input wire logic irqReq,
   // bench knobs: stall the core, handler length
   input wire logic ackEnable,
   input wire logic [7:0] handlerCycles,
   // handshake back to the controller
   output tlvic_pkg::tlvic_core_type coreIn
);
   import tlvic_pkg::*;
   int depth;
   int left [2];
   logic ackNow;
   logic retiNow;
   // handler stack, only the innermost handler makes progress
   always @(posedge clk_sys) begin
      ackNow = 1'b0;
      retiNow = 1'b0;
      if (reset) begin
         depth = 0;
      end else begin
         if (coreIn.ack && irqReq && depth < 2) begin
            left[depth] = handlerCycles;
            depth++;
         end else if (depth > 0 && left[depth-1] == 0) begin
            retiNow = 1'b1;
            depth--;
         end else if (depth > 0) begin
            left[depth-1]--;
         end
         // one ack per offer, never beside a reti
         ackNow = ackEnable && irqReq && !coreIn.ack && !retiNow;
      end
      coreIn <= '{ack: ackNow, reti: retiNow};
   end
endmodule

// ==== tlvic_top_test.sv ====
// self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
module tlvic_top_test;
   import tlvic_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   tlvic_bus_type regBus = '0;
   logic [7:0] rdData;
   logic extRequest0Pin = 1'b1;
   logic extRequest1Pin = 1'b1;
   logic timer0Overflow = 1'b0;
   logic timer1Overflow = 1'b0;
   logic uartRxDone = 1'b0;
   logic uartTxDone = 1'b0;
   logic timer2OverflowFlag = 1'b0;
   logic timer2ExternalFlag = 1'b0;
   logic timer0Run, timer1Run, irqReq, irqHigh, intOut;
   logic [15:0] irqVector;
   tlvic_core_type coreIn;
   logic ackEnable = 1'b1;
   logic [7:0] handlerCycles = 8'h04;
   logic [16:0] takeLog [$];
   logic [7:0] regAddr [5] = '{8'h88, 8'ha8, 8'hb8, 8'he8, 8'he9};
   logic [7:0] runVal [4] = '{8'h50, 8'h10, 8'h40, 8'h00};
   int errors = 0;
   int nChecks = 0;
   int n0, n1;

   always #50 clk_sys = ~clk_sys;

   tlvic_top tlvic_top_inst (.clk_sys(clk_sys), .reset(reset), .regBus(regBus),
      .rdData(rdData), .extRequest0Pin(extRequest0Pin), .extRequest1Pin(extRequest1Pin),
      .timer0Overflow(timer0Overflow), .timer1Overflow(timer1Overflow),
      .uartRxDone(uartRxDone), .uartTxDone(uartTxDone),
      .timer2OverflowFlag(timer2OverflowFlag), .timer2ExternalFlag(timer2ExternalFlag),
      .timer0Run(timer0Run), .timer1Run(timer1Run), .coreIn(coreIn), .irqReq(irqReq),
      .irqHigh(irqHigh), .irqVector(irqVector), .intOut(intOut));

   tlvic_core_model tlvic_core_model_inst (.clk_sys(clk_sys), .reset(reset),
      .irqReq(irqReq), .ackEnable(ackEnable), .handlerCycles(handlerCycles),
      .coreIn(coreIn));

   // log taken vectors; acting as software, drop the level sources once served
   always @(posedge clk_sys) begin
      if (!reset && coreIn.ack === 1'b1 && irqReq === 1'b1) begin
         takeLog.push_back({irqHigh, irqVector});
         if (irqVector === 16'h0023) begin
            uartRxDone <= 1'b0;
            uartTxDone <= 1'b0;
         end
         if (irqVector === 16'h002b) begin
            timer2OverflowFlag <= 1'b0;
            timer2ExternalFlag <= 1'b0;
         end
      end
   end

   task automatic results();
      if (errors == 0 && nChecks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [16:0] exp, input logic [16:0] got);
      nChecks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         errors++;
      end
   endtask

   // ends on the edge that takes the strobe
   task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      regBus.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic regCheck(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      regBus.rd <= 1'b0;
      #1;
      check($sformatf("reg %h", a), {9'h000, e}, {9'h000, rdData});
   endtask

   task automatic pulseTimer(input logic one);
      @(posedge clk_sys);
      timer0Overflow <= !one;
      timer1Overflow <= one;
      @(posedge clk_sys);
      timer0Overflow <= 1'b0;
      timer1Overflow <= 1'b0;
   endtask

   task automatic waitTakes(input int n);
      for (int k = 0; k < 600 && takeLog.size() < n; k++) @(posedge clk_sys);
      if (takeLog.size() < n) begin
         $display("[ERR] takes expected %0d seen %0d", n, takeLog.size());
         errors++;
         results();
      end
   endtask

   // counts cycles with a request offered; a gated source must give none
   task automatic quiet(input int n);
      int hits = 0;
      repeat (n) begin
         @(posedge clk_sys);
         #1;
         if (irqReq !== 1'b0) hits++;
      end
      check("irqReq quiet", 17'h0, 17'(hits));
   endtask

   initial begin
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      foreach (regAddr[k]) regCheck(regAddr[k], 8'h00);
      // reserved bits are always written as zero
      regWrite(8'ha8, 8'hbf);
      regCheck(8'ha8, 8'hbf);
      regWrite(8'hb8, 8'h3f);
      regCheck(8'hb8, 8'h3f);
      regWrite(8'h10, 8'hff);
      regCheck(8'h10, 8'h00);
      regWrite(8'ha8, 8'h00);
      regWrite(8'hb8, 8'h00);
      // run bits follow software writes
      foreach (runVal[k]) begin
         regWrite(8'h88, runVal[k]);
         #1;
         check("runs", {15'h0, runVal[k][6], runVal[k][4]}, {15'h0, timer1Run, timer0Run});
         regCheck(8'h88, runVal[k]);
      end
      // global enable off keeps a pending timer 0 request back
      regWrite(8'ha8, 8'h3f);
      pulseTimer(1'b0);
      quiet(12);
      regCheck(8'h88, 8'h20);
      regWrite(8'he8, 8'h0f);
      takeLog.delete();
      regWrite(8'ha8, 8'h82);
      waitTakes(1);
      check("vector", 17'h0000b, takeLog[0]);
      regCheck(8'h88, 8'h00);
      regCheck(8'he8, 8'h01);
      regWrite(8'he9, 8'h01);
      #1;
      check("intOut set", 17'h1, {16'h0, intOut});
      regWrite(8'he8, 8'h01);
      #1;
      check("intOut clear", 17'h0, {16'h0, intOut});
      regWrite(8'he9, 8'h00);
      // own enable bit holds timer 2 back
      takeLog.delete();
      regWrite(8'ha8, 8'h80);
      timer2OverflowFlag <= 1'b1;
      quiet(10);
      regWrite(8'ha8, 8'ha0);
      waitTakes(1);
      check("vector", 17'h0002b, takeLog[0]);
      // six sources at once on one level while the core stalls
      repeat (10) @(posedge clk_sys);
      takeLog.delete();
      ackEnable <= 1'b0;
      regWrite(8'h88, 8'h05);
      regWrite(8'ha8, 8'hbf);
      extRequest0Pin <= 1'b0;
      extRequest1Pin <= 1'b0;
      uartRxDone <= 1'b1;
      timer2ExternalFlag <= 1'b1;
      pulseTimer(1'b0);
      pulseTimer(1'b1);
      repeat (8) @(posedge clk_sys);
      extRequest0Pin <= 1'b1;
      extRequest1Pin <= 1'b1;
      ackEnable <= 1'b1;
      waitTakes(6);
      for (int k = 0; k < 6; k++) check("order", {1'b0, 16'h0003 + 16'(8 * k)}, takeLog[k]);
      // long low handler: only the high source may cut in
      repeat (10) @(posedge clk_sys);
      takeLog.delete();
      handlerCycles <= 8'h14;
      regWrite(8'hb8, 8'h08);
      regWrite(8'ha8, 8'h9a);
      pulseTimer(1'b0);
      waitTakes(1);
      uartTxDone <= 1'b1;
      repeat (3) @(posedge clk_sys);
      pulseTimer(1'b1);
      waitTakes(3);
      check("nest 0", 17'h0000b, takeLog[0]);
      check("nest 1", 17'h1001b, takeLog[1]);
      check("nest 2", 17'h00023, takeLog[2]);
      regCheck(8'he8, 8'h0f);
      // ext0 on falling edge, ext1 on low level, both pins held low
      repeat (60) @(posedge clk_sys);
      takeLog.delete();
      handlerCycles <= 8'h04;
      regWrite(8'hb8, 8'h00);
      regWrite(8'h88, 8'h01);
      regWrite(8'ha8, 8'h85);
      extRequest0Pin <= 1'b0;
      extRequest1Pin <= 1'b0;
      repeat (60) @(posedge clk_sys);
      extRequest0Pin <= 1'b1;
      extRequest1Pin <= 1'b1;
      repeat (30) @(posedge clk_sys);
      n0 = 0;
      n1 = 0;
      foreach (takeLog[k]) begin
         if (takeLog[k] === 17'h00003) n0++;
         if (takeLog[k] === 17'h00013) n1++;
      end
      check("edge takes", 17'h1, 17'(n0));
      check("level takes", 17'h1, {16'h0, n1 > 1});
      results();
   end
endmodule
